// ---- dv/power_stage_model.sv ----
// Purpose: Behavioural power stage that reports its regulation state to the fault block.
// Assumes: The bench picks the regulation mode the loaded stage would settle into.
// Notes:   With the output disabled the stage regulates nothing, so both flags drop.
`timescale 1ns/1ps

module power_stage_model
    import fault_report_pkg::*;
(
    // Clock.
    input  wire logic       hclk,
    // Control from the device and the bench.
    input  wire logic       output_enable,
    input  wire reg_state_s want,
    // Regulation flags back to the device.
    output reg_state_s      stage_state
);
    // ======================================================================
    // Regulation state
    // ======================================================================
    // A disabled output regulates nothing; held flags would hide a trip.
    always_ff @(posedge hclk) begin
        stage_state <= output_enable ? want : '0;
    end
endmodule

// ---- dv/supply_fault_holdoff_and_error_report_tb_top.sv ----
// Purpose: Self-checking bench of the fault report block over AHB-Lite.
// Assumes: A short hold-off tick so that delays fit in a short run.
// Notes:   Each scenario task drives the block and judges the answers itself.
`timescale 1ns/1ps
`include "fault_report_consts.svh"

module supply_fault_holdoff_and_error_report_tb_top
    import fault_report_pkg::*;
;
    localparam int TICK = 4;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    reg_state_s  stage_state;
    reg_state_s  want;
    logic        output_enable;
    logic        fault_line;
    logic        error_led;
    int          n_errors;
    int          n_compared;

    fault_report #(.TICK_CYCLES(TICK)) i_fault_report (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .stage_state(stage_state), .output_enable(output_enable),
        .fault_line(fault_line), .error_led(error_led));

    power_stage_model i_power_stage_model (
        .hclk(hclk), .output_enable(output_enable), .want(want),
        .stage_state(stage_state));

    // ======================================================================
    // Clock and watchdog
    // ======================================================================
    // The clock toggles every 20 ns, half of its 40 ns period.
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // A hang is counted as a mismatch; the whole run needs far fewer cycles.
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        tally_and_finish();
    end

    // ======================================================================
    // Helpers
    // ======================================================================
    task automatic tally_and_finish();
        $display("Compared %0d values, %0d mismatches", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One single word transfer; each phase is held until hready is seen high.
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb(a, 1'b1, d, unused);
    endtask

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] got;
        ahb(a, 1'b0, 32'h0, got);
        chk(what, exp, got);
    endtask

    // ======================================================================
    // Scenarios
    // ======================================================================
    // Values after reset, and an unmapped place that reads zero.
    task automatic t_reset_values();
        rd_chk("holdoff", `OFS_HOLDOFF, 32'h10);
        rd_chk("mcp_mode", `OFS_MCP_MODE, 32'h0);
        rd_chk("fault", `OFS_FAULT, 32'h0);
        rd_chk("errnum", `OFS_ERRNUM, 32'h0);
        rd_chk("unmapped", 12'h0f0, 32'h0);
    endtask

    // Hold-off range ends, and every protect mode code with an illegal one.
    task automatic t_settings();
        wr(`OFS_HOLDOFF, 32'h3e8);
        rd_chk("holdoff_max", `OFS_HOLDOFF, 32'h3e8);
        wr(`OFS_HOLDOFF, 32'h3e9);
        rd_chk("holdoff_sat", `OFS_HOLDOFF, 32'h3e8);
        wr(`OFS_HOLDOFF, 32'h0);
        rd_chk("holdoff_zero", `OFS_HOLDOFF, 32'h0);
        for (int m = 0; m < 3; m++) begin
            wr(`OFS_MCP_MODE, 32'(m));
            rd_chk("mcp_mode", `OFS_MCP_MODE, 32'(m));
        end
        wr(`OFS_MCP_MODE, 32'h3);
        rd_chk("mcp_bad", `OFS_MCP_MODE, 32'h2);
    endtask

    // An error discards the rest of the line, is reported, and can be suppressed.
    task automatic t_error();
        wr(`OFS_COMMAND, 32'h0540);
        wr(`OFS_COMMAND, 32'h0010);
        @(posedge hclk);
        chk("oe_discard", 32'h0, 32'(output_enable));
        chk("led", 32'h1, 32'(error_led));
        chk("fault_line", 32'h1, 32'(fault_line));
        wr(`OFS_COMMAND, 32'h0080);
        rd_chk("accum", `OFS_ACCUM, 32'h8);
        rd_chk("errnum", `OFS_ERRNUM, 32'h5);
        rd_chk("accum_clr", `OFS_ACCUM, 32'h0);
        rd_chk("fault_sum", `OFS_FAULT, 32'h8);
        @(posedge hclk);
        chk("line_clr", 32'h0, 32'(fault_line));
        wr(`OFS_SUPPRESS, 32'h8);
        wr(`OFS_COMMAND, 32'h07c0);
        rd_chk("fault_supp", `OFS_FAULT, 32'h0);
        rd_chk("errnum2", `OFS_ERRNUM, 32'h7);
        wr(`OFS_SUPPRESS, 32'h0);
    endtask

    // Mode changes inside the hold-off are ignored; after it a CC to CV change trips.
    task automatic t_trip();
        wr(`OFS_MCP_MODE, 32'h1);
        wr(`OFS_HOLDOFF, 32'ha);
        wr(`OFS_COMMAND, 32'h0010);
        want <= '{cv: 1'b0, cc: 1'b1};
        repeat (5) @(posedge hclk);
        want <= '{cv: 1'b1, cc: 1'b0};
        repeat (10) @(posedge hclk);
        chk("holdoff_line", 32'h0, 32'(fault_line));
        chk("holdoff_oe", 32'h1, 32'(output_enable));
        repeat (40) @(posedge hclk);
        want <= '{cv: 1'b0, cc: 1'b1};
        repeat (8) @(posedge hclk);
        want <= '{cv: 1'b1, cc: 1'b0};
        repeat (8) @(posedge hclk);
        chk("trip_oe", 32'h0, 32'(output_enable));
        chk("trip_line", 32'h1, 32'(fault_line));
        repeat (10) @(posedge hclk);
        chk("stay_off", 32'h0, 32'(output_enable));
        rd_chk("trip_sum", `OFS_FAULT, 32'h7);
        wr(`OFS_COMMAND, 32'h0004);
        @(posedge hclk);
        chk("recover", 32'h1, 32'(output_enable));
        rd_chk("state_run", `OFS_STATE, 32'h0000_0a06);
    endtask

    // The setpoint, recover and apply commands reload the hold-off count; output off drops the output.
    task automatic t_commands();
        wr(`OFS_HOLDOFF, 32'h20);
        for (int b = 0; b < 4; b++) begin
            wr(`OFS_COMMAND, 32'h1 << b);
            rd_chk("state_reload", `OFS_STATE, 32'h0000_2006);
        end
        wr(`OFS_COMMAND, 32'h0020);
        @(posedge hclk);
        chk("out_off", 32'h0, 32'(output_enable));
        rd_chk("holdoff_q", `OFS_HOLDOFF, 32'h20);
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        n_errors   = 0;
        n_compared = 0;
        hresetn    = 1'b0;
        hsel       = 1'b0;
        haddr      = 12'h000;
        htrans     = 2'h0;
        hwrite     = 1'b0;
        hsize      = 3'h2;
        hwdata     = 32'h0;
        want       = '0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_settings();
        t_error();
        t_trip();
        t_commands();
        tally_and_finish();
    end
endmodule

// ---- hdl/fault_report.sv ----
// Purpose: Fault hold-off, programming error report, fault register and mode-change protect.
// Assumes: Firmware parses the text line and posts decoded events to the command register.
// Notes:   Reads of the fault and error registers clear state as queries do.
//
// Contract
// - Hold-off delay accepts 0 to 32 s in 32 ms steps.
// - Hold-off delay is 0.5 s after reset.
// - Setpoint, recover, apply or output-on commands restart the hold-off delay.
// - While hold-off runs, CV, CC and protect conditions raise no faults.
// - Hold-off query returns the programmed delay value.
// - Programming error lights error indicator, sets error bit in accumulated and fault.
// - Suppressed error bit is not set by an error.
// - After an error, the rest of the command line is discarded.
// - Error query returns last error number, clears accumulated error bit.
// - A fault sets its fault register bit when it arises.
// - Suppressed bits are never set in the fault register.
// - Any set fault bit asserts the fault output line.
// - Fault query clears the fault register and the fault line.
// - Fault query answers with the weighted sum of set bits.
// - Protect mode codes: 0 off, 1 CV trip, 2 CC trip.
// - Entering the selected protect condition disables the output.
// - Output stays disabled after a trip until the recover command; the code also re-enables it on the output-on command.
// - CV trip selected: CC to CV change disables the output.
// - Protect mode is off after reset.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "fault_report_consts.svh"

module fault_report
    import fault_report_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Power stage regulation state, asynchronous to hclk.
    input  wire reg_state_s  stage_state,
    // Outputs to the power stage and front panel.
    output logic             output_enable,
    output logic             fault_line,
    output logic             error_led
);

    // ======================================================================
    // Bus address phase capture
    // ======================================================================
    logic [11:0] addr_reg;
    logic        wr_reg;
    logic        rd_reg;
    logic        take;

    assign take      = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Writes complete in the data phase, so the address is held one cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_reg <= 12'h000;
            wr_reg   <= 1'b0;
            rd_reg   <= 1'b0;
        end else begin
            addr_reg <= haddr;
            wr_reg   <= take && hwrite;
            rd_reg   <= take && !hwrite;
        end
    end

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    logic we_holdoff;
    logic we_mode;
    logic we_cmd;
    logic we_supp;
    logic rd_fault;
    logic rd_err;
    assign we_holdoff = wr_reg && hit(addr_reg, `OFS_HOLDOFF);
    assign we_mode    = wr_reg && hit(addr_reg, `OFS_MCP_MODE);
    assign we_cmd     = wr_reg && hit(addr_reg, `OFS_COMMAND);
    assign we_supp    = wr_reg && hit(addr_reg, `OFS_SUPPRESS);
    assign rd_fault   = rd_reg && hit(addr_reg, `OFS_FAULT);
    assign rd_err     = rd_reg && hit(addr_reg, `OFS_ERRNUM);

    // ======================================================================
    // Input synchroniser for the regulation state
    // ======================================================================
    reg_state_s st_meta_reg;
    reg_state_s st_reg;
    reg_state_s st_prev_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_meta_reg <= '0;
            st_reg      <= '0;
            st_prev_reg <= '0;
        end else begin
            st_meta_reg <= stage_state;
            st_reg      <= st_meta_reg;
            st_prev_reg <= st_reg;
        end
    end

    // ======================================================================
    // Configuration registers
    // ======================================================================
    logic [`HOLDOFF_W-1:0] holdoff_reg;
    mcp_mode_e             mcp_reg;
    cond_t                 supp_reg;
    logic                  discard_reg;
    logic [7:0]            cmd;

    // Command strobes are dropped while the rest of a bad line is discarded.
    assign cmd = (we_cmd && !discard_reg) ? hwdata[7:0] : 8'h00;

    // Delay in 32 ms ticks; out-of-range values saturate at 32 s.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            holdoff_reg <= `HOLDOFF_RESET;
        end else if (we_holdoff) begin
            holdoff_reg <= (hwdata[31:`HOLDOFF_W] != '0 || hwdata[`HOLDOFF_W-1:0] > `HOLDOFF_MAX)
                           ? `HOLDOFF_MAX : hwdata[`HOLDOFF_W-1:0];
        end
    end

    property p_holdoff_rng;
        @(posedge hclk) disable iff (!hresetn) holdoff_reg <= `HOLDOFF_MAX;
    endproperty
    a_holdoff_rng: assert property (p_holdoff_rng)
        else $error("hold-off above 32 s");

    // Unknown codes are ignored so the protect setting never leaves its legal set.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mcp_reg <= MCP_OFF;
        end else if (we_mode && hwdata[31:2] == '0 && hwdata[1:0] != 2'h3) begin
            mcp_reg <= mcp_mode_e'(hwdata[1:0]);
        end
    end

    property p_mcp_legal;
        @(posedge hclk) disable iff (!hresetn) mcp_reg != 2'h3;
    endproperty
    a_mcp_legal: assert property (p_mcp_legal)
        else $error("illegal protect mode");

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            supp_reg <= '0;
        end else if (we_supp) begin
            supp_reg <= hwdata[`COND_W-1:0];
        end
    end

    // ======================================================================
    // Programming error capture and line discard
    // ======================================================================
    logic [`ERRNUM_W-1:0] errnum_reg;
    logic                 err_evt;
    assign err_evt = we_cmd && !discard_reg && hwdata[`CMD_ERROR];

    // Discard lasts until the end-of-line strobe of the offending line.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            discard_reg <= 1'b0;
        end else if (err_evt && !hwdata[`CMD_EOL]) begin
            discard_reg <= 1'b1;
        end else if (we_cmd && hwdata[`CMD_EOL]) begin
            discard_reg <= 1'b0;
        end
    end

    // A discarded write must leave no trace in the error number or the output.
    sequence s_line_discarded;
        discard_reg && we_cmd;
    endsequence
    property p_discard;
        @(posedge hclk) disable iff (!hresetn)
        s_line_discarded |=> $stable(errnum_reg) && !$rose(output_enable);
    endproperty
    a_discard: assert property (p_discard)
        else $error("command executed while discarding");

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            errnum_reg <= '0;
            error_led  <= 1'b0;
        end else if (err_evt) begin
            errnum_reg <= hwdata[`CMD_ERRNUM_LSB +: `ERRNUM_W];
            error_led  <= 1'b1;
        end
    end

    // ======================================================================
    // Hold-off counter
    // ======================================================================
    logic [31:0]           tick_cnt_reg;
    logic [`HOLDOFF_W-1:0] ho_cnt_reg;
    logic                  restart;
    logic                  holdoff_run;
    assign restart = cmd[`CMD_VOLT_SET] | cmd[`CMD_CURR_SET] | cmd[`CMD_RECOVER]
                   | cmd[`CMD_APPLY] | cmd[`CMD_OUT_ON];
    assign holdoff_run = (ho_cnt_reg != '0);

    // Starts at zero so faults are live at once after reset until a command arrives.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ho_cnt_reg   <= '0;
            tick_cnt_reg <= 32'h0;
        end else if (restart) begin
            ho_cnt_reg   <= holdoff_reg;
            tick_cnt_reg <= 32'h0;
        end else if (holdoff_run) begin
            if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
                tick_cnt_reg <= 32'h0;
                ho_cnt_reg   <= ho_cnt_reg - 1'b1;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'h1;
            end
        end
    end

    property p_restart;
        @(posedge hclk) disable iff (!hresetn) restart |=> ho_cnt_reg == $past(holdoff_reg);
    endproperty
    a_restart: assert property (p_restart)
        else $error("hold-off not restarted");

    // ======================================================================
    // Fault conditions and protect trip
    // ======================================================================
    cond_t raw;
    logic  mcp_trip;
    assign mcp_trip = ((mcp_reg == MCP_CV) && st_reg.cv && !st_prev_reg.cv)
                   || ((mcp_reg == MCP_CC) && st_reg.cc && !st_prev_reg.cc);

    // Mode conditions are masked during hold-off; the error bit never is.
    always_comb begin
        raw            = '0;
        raw[`BIT_CV]   = st_reg.cv && !st_prev_reg.cv && !holdoff_run;
        raw[`BIT_CC]   = st_reg.cc && !st_prev_reg.cc && !holdoff_run;
        raw[`BIT_MCP]  = mcp_trip && !holdoff_run;
        raw[`BIT_ERR]  = err_evt;
    end

    // ======================================================================
    // Fault and accumulated registers
    // ======================================================================
    cond_t fault_reg;
    cond_t accum_reg;
    cond_t set_bits;
    assign set_bits = raw & ~supp_reg;

    // A new fault in the read cycle survives the clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_reg <= '0;
        end else begin
            fault_reg <= (rd_fault ? '0 : fault_reg) | set_bits;
        end
    end

    // New fault bits must all come from conditions that were unmasked.
    property p_supp;
        @(posedge hclk) disable iff (!hresetn)
        (fault_reg & ~$past(fault_reg) & $past(supp_reg)) == '0;
    endproperty
    a_supp: assert property (p_supp)
        else $error("suppressed fault bit set");
    property p_holdoff_mask;
        @(posedge hclk) disable iff (!hresetn)
        holdoff_run |=> (fault_reg[`BIT_MCP:`BIT_CV]
                         & ~$past(fault_reg[`BIT_MCP:`BIT_CV])) == 3'h0;
    endproperty
    a_holdoff_mask: assert property (p_holdoff_mask)
        else $error("mode fault raised during hold-off");

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accum_reg <= '0;
        end else begin
            accum_reg <= accum_reg | set_bits;
            if (rd_err && !set_bits[`BIT_ERR]) begin
                accum_reg[`BIT_ERR] <= 1'b0;
            end
        end
    end

    assign fault_line = (fault_reg != '0);

    property p_fault_line;
        @(posedge hclk) disable iff (!hresetn) (set_bits != '0) |=> fault_line;
    endproperty
    a_fault_line: assert property (p_fault_line)
        else $error("fault line low after a fault bit was set");

    // An unsuppressed error shows in both registers and on the indicator.
    sequence s_error_reported;
        fault_reg[`BIT_ERR] && accum_reg[`BIT_ERR] && error_led;
    endsequence
    property p_err_set;
        @(posedge hclk) disable iff (!hresetn)
        (err_evt && !supp_reg[`BIT_ERR]) |=> s_error_reported;
    endproperty
    a_err_set: assert property (p_err_set)
        else $error("error not reported");

    // ======================================================================
    // Output enable
    // ======================================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            output_enable <= 1'b0;
        end else if (raw[`BIT_MCP]) begin
            output_enable <= 1'b0;
        end else if (cmd[`CMD_RECOVER] || cmd[`CMD_OUT_ON]) begin
            output_enable <= 1'b1;
        end else if (cmd[`CMD_OUT_OFF]) begin
            output_enable <= 1'b0;
        end
    end

    property p_trip_off;
        @(posedge hclk) disable iff (!hresetn) raw[`BIT_MCP] |=> !output_enable;
    endproperty
    a_trip_off: assert property (p_trip_off)
        else $error("output still on after protect trip");

    // ======================================================================
    // Read data
    // ======================================================================
    // Read data is combinational from state in the data phase.
    always_comb begin
        hrdata = 32'h0;
        if (rd_reg) begin
            if (hit(addr_reg, `OFS_HOLDOFF)) hrdata = {22'h0, holdoff_reg};
            if (hit(addr_reg, `OFS_MCP_MODE)) hrdata = {30'h0, mcp_reg};
            if (hit(addr_reg, `OFS_SUPPRESS)) hrdata = {28'h0, supp_reg};
            if (hit(addr_reg, `OFS_FAULT)) hrdata = {28'h0, fault_reg};
            if (hit(addr_reg, `OFS_ACCUM)) hrdata = {28'h0, accum_reg};
            if (hit(addr_reg, `OFS_ERRNUM)) hrdata = {24'h0, errnum_reg};
            if (hit(addr_reg, `OFS_STATE)) begin
                hrdata = {14'h0, ho_cnt_reg, 4'h0, discard_reg, holdoff_run,
                          output_enable, fault_line};
            end
        end
    end

endmodule

// ---- hdl/fault_report_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the fault report block.
// Assumes: 25 MHz hclk, AHB-Lite register access with one word per register.
// Notes:   Included by the package and by the design module.
`ifndef FAULT_REPORT_CONSTS_SVH
`define FAULT_REPORT_CONSTS_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define OFS_HOLDOFF     12'h000
`define OFS_MCP_MODE    12'h004
`define OFS_COMMAND     12'h008
`define OFS_SUPPRESS    12'h00c
`define OFS_FAULT       12'h010
`define OFS_ACCUM       12'h014
`define OFS_ERRNUM      12'h018
`define OFS_STATE       12'h01c

// ==========================================================================
// Condition bit positions, shared by fault, accumulated and suppress words
// ==========================================================================
`define BIT_CV          0
`define BIT_CC          1
`define BIT_MCP         2
`define BIT_ERR         3
`define COND_W          4

// ==========================================================================
// Command word layout: strobe bits and error number field
// ==========================================================================
`define CMD_VOLT_SET    0
`define CMD_CURR_SET    1
`define CMD_RECOVER     2
`define CMD_APPLY       3
`define CMD_OUT_ON      4
`define CMD_OUT_OFF     5
`define CMD_ERROR       6
`define CMD_EOL         7
`define CMD_ERRNUM_LSB  8
`define ERRNUM_W        8

// ==========================================================================
// Hold-off timing
// ==========================================================================
`define TICK_MS         32
`define CLK_KHZ         25000
`define TICK_CYCLES     (`TICK_MS * `CLK_KHZ)
`define HOLDOFF_W       10
`define HOLDOFF_MAX     10'h3e8
`define HOLDOFF_RESET   10'h010
`define MCP_RESET       2'h0

`endif

// ---- hdl/fault_report_pkg.sv ----
// Purpose: Types of the fault report block.
// Assumes: Constants come from the consts header.
// Notes:   Mode-change-protect selection is a two-bit code.
`include "fault_report_consts.svh"

package fault_report_pkg;

    // ======================================================================
    // Mode-change-protect selection
    // ======================================================================
    typedef enum logic [1:0] {
        MCP_OFF = 2'h0,
        MCP_CV  = 2'h1,
        MCP_CC  = 2'h2
    } mcp_mode_e;

    // Live regulation state from the power stage.
    typedef struct packed {
        logic cv;
        logic cc;
    } reg_state_s;

    typedef logic [`COND_W-1:0] cond_t;

endpackage
